// [shared/miss_if.sv]
// Bundle between the top and one miss detector.
// The top drives access and configuration; the detector answers.
`timescale 1ns/1ps
interface miss_if;
  import soft_cache_ram_pkg::*;
  logic  valid, is_read, en, ack, fixed, split, upper;
  addr_t addr, rmask, pmask, match, page;
  phys_t base, phys;
  logic  flag, hit, miss;
  modport det (input valid, is_read, en, ack, fixed, split, upper,
               input addr, rmask, pmask, match, base,
               output flag, page, hit, miss, phys);
  modport ctl (output valid, is_read, en, ack, fixed, split, upper,
               output addr, rmask, pmask, match, base,
               input flag, page, hit, miss, phys);
endinterface

// [shared/soft_cache_ram_pkg.sv]
// Constants, register map and field layout of the soft cache miss trap.
// Shared by the top, the miss detectors and the exception gate.
package soft_cache_ram_pkg;
  localparam int ADDR_W   = 24;
  localparam int PHYS_W   = 16;
  localparam int NUM_UNIT = 2;
  localparam int NUM_IRQ  = 4;
  localparam int REG_AW   = 6;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [PHYS_W-1:0] phys_t;
  typedef logic [REG_AW-1:0] ofs_t;

  // Byte offsets on the register port
  localparam ofs_t OFS_CMD   = 6'h00;
  localparam ofs_t OFS_FLAGS = 6'h00;
  localparam ofs_t OFS_ISTAT = 6'h30;
  localparam ofs_t OFS_IMASK = 6'h34;
  localparam ofs_t OFS_BASE  [NUM_UNIT] = '{6'h04, 6'h08};
  localparam ofs_t OFS_RMASK [NUM_UNIT] = '{6'h10, 6'h20};
  localparam ofs_t OFS_PMASK [NUM_UNIT] = '{6'h14, 6'h24};
  localparam ofs_t OFS_MATCH [NUM_UNIT] = '{6'h18, 6'h28};
  localparam ofs_t OFS_PAGE  [NUM_UNIT] = '{6'h1c, 6'h2c};

  // miss_unit_command bits
  localparam int CMD_DATA_ON  = 0;
  localparam int CMD_INSN_ON  = 1;
  localparam int CMD_DATA_ACK = 2;
  localparam int CMD_INSN_ACK = 3;
  // miss_unit_flags bits
  localparam int FLG_DATA_MISS = 0;
  localparam int FLG_INSN_MISS = 1;
  localparam int FLG_DATA_ON   = 2;
  localparam int FLG_INSN_ON   = 3;

  // Values after reset; ZERO_OFS replaces the base under fixed mapping
  localparam addr_t RST_ADDR = 24'h00_0000;
  localparam phys_t RST_BASE = 16'h0000;
  localparam phys_t ZERO_OFS = 16'h0000;
endpackage

// [src/exc_gate.sv]
// Exception gate in front of the CPU interrupt line.
// Assumes plain interrupt requests are levels on i_clk.
`timescale 1ns/1ps
module exc_gate
  import soft_cache_ram_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_exc,
  input  wire logic [NUM_IRQ-1:0] i_irq,
  output logic                    o_int,
  output logic                    o_exc_sel
);
  typedef struct packed {
    logic raise;
    logic exc_sel;
  } gate_state_t;

  gate_state_t s_q, s_d;

  always_comb begin
    s_d.exc_sel = i_exc;
    // Exception wins and masks requests until one cycle after its cause clears
    s_d.raise   = i_exc | ((|i_irq) & ~s_q.exc_sel);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{raise: 1'b0, exc_sel: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_int     = s_q.raise;
  assign o_exc_sel = s_q.exc_sel;

  a_exc_blocks_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(i_exc) |=> (o_exc_sel && o_int) ##1 (o_int || !$past(i_exc)))
    else $error("exception did not take the interrupt line");
endmodule

// [src/miss_detect.sv]
// One miss detector: region compare, miss capture and translation.
// Assumes access and configuration are steady within the clock cycle.
`timescale 1ns/1ps
module miss_detect
  import soft_cache_ram_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  miss_if.det       bus
);
  typedef struct packed {
    logic  flag;
    logic  loaded;
    addr_t page;
  } det_state_t;

  det_state_t s_q, s_d;
  addr_t      page_now, in_page;
  logic       in_region, same_page, act;
  phys_t      ofs;

  always_comb begin
    in_region = (bus.addr & bus.rmask) == bus.match;
    page_now  = bus.fixed ? (bus.addr & bus.rmask)
                          : (bus.addr & bus.rmask & bus.pmask);
    in_page   = bus.fixed ? (bus.addr & ~bus.rmask)
                          : (bus.addr & ~(bus.rmask | bus.pmask));
    same_page = s_q.loaded && (page_now == s_q.page);
    act       = bus.valid && bus.en;
    // Pending miss stalls the unit: no hit and no second capture
    bus.miss  = act && bus.is_read && in_region && !same_page && !s_q.flag;
    bus.hit   = act && in_region && same_page && !s_q.flag;
    ofs       = (bus.fixed ? ZERO_OFS : bus.base) + phys_t'(in_page);
    bus.phys  = bus.split ? {bus.upper, ofs[PHYS_W-2:0]} : ofs;
    s_d = s_q;
    if (!bus.en) begin
      s_d.loaded = 1'b0;
    end
    if (bus.ack) begin
      s_d.loaded = s_q.flag;
      s_d.flag   = 1'b0;
    end
    if (bus.miss) begin
      s_d.flag   = 1'b1;
      s_d.loaded = 1'b0;
      s_d.page   = page_now;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{flag: 1'b0, loaded: 1'b0, page: RST_ADDR};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.flag = s_q.flag;
  assign bus.page = s_q.page;
endmodule

// [src/soft_cache_miss_trap.sv]
// Soft cache miss trap: register port, data and instruction miss units,
// translation into cache RAM and the exception path to the CPU.
// Assumes loads, fetches and the register port are logic on i_clk.
// Function
// - Every CPU load or fetch address is checked against a watched region.
// - Only reads in a watched region raise the miss exception, never writes.
// - Region hit means address AND region mask equals region match value.
// - On miss, store address AND page mask AND region mask as page.
// - Reading the miss page register gives the faulting page base address.
// - Data detection and translation act only while data translation is on.
// - Command write with data acknowledge clears the data miss flag.
// - The miss goes out through the exception channel, vector zero.
// - Optional second unit serves fetches with its own registers.
// - With fetch translation on, RAM lower half is data, upper half code.
// - With fetch translation off, data may use the whole cache RAM.
// - Flags register shows separate data miss and fetch miss bits.
// - Fetch miss traps on virtual address; later fetches use translated address.
// - Each unit adds its page base register to form the RAM address.
// - Fixed mapping ignores page masks and bases; data may reach both halves.
// - Data reads of code pages trap only if the data mask covers them.
// - Exception overrides interrupt requests and blocks them until one cycle after it clears.
`timescale 1ns/1ps
module soft_cache_miss_trap
  import soft_cache_ram_pkg::*;
#(
  parameter bit SECOND_INSTANCE_OPTION = 1'b1,
  parameter bit FIXED_MAPPING_OPTION   = 1'b0
) (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic [REG_AW-1:0]  i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  input  wire logic               i_ld_valid,
  input  wire logic               i_ld_write,
  input  wire logic [ADDR_W-1:0]  i_ld_addr,
  input  wire logic               i_if_valid,
  input  wire logic [ADDR_W-1:0]  i_if_addr,
  input  wire logic [NUM_IRQ-1:0] i_irq_src,
  output logic                    o_ld_hit,
  output logic      [PHYS_W-1:0]  o_ld_phys,
  output logic                    o_if_hit,
  output logic      [PHYS_W-1:0]  o_if_phys,
  output logic                    o_cpu_int,
  output logic                    o_exc_vector_zero,
  output logic                    o_irq
);
  typedef struct packed {
    logic                         data_on;
    logic                         insn_on;
    logic [NUM_UNIT-1:0][ADDR_W-1:0] rmask;
    logic [NUM_UNIT-1:0][ADDR_W-1:0] pmask;
    logic [NUM_UNIT-1:0][ADDR_W-1:0] match;
    logic [NUM_UNIT-1:0][PHYS_W-1:0] base;
    logic [NUM_UNIT-1:0]          istat;
    logic [NUM_UNIT-1:0]          imask;
    logic [31:0]                  rdata;
    logic [NUM_UNIT-1:0]          hit;
    logic [NUM_UNIT-1:0][PHYS_W-1:0] phys;
    logic                         irq;
  } top_state_t;

  top_state_t          s_q, s_d;
  logic [NUM_UNIT-1:0] ack;
  logic [NUM_UNIT-1:0] acc_v;
  logic [NUM_UNIT-1:0] acc_rd;
  logic [NUM_UNIT-1:0] unit_en;
  logic [NUM_UNIT-1:0] unit_split;
  logic [NUM_UNIT-1:0] miss_v;
  logic [NUM_UNIT-1:0] hit_v;
  logic [NUM_UNIT-1:0] flag_v;
  addr_t               acc_a  [NUM_UNIT];
  addr_t               page_v [NUM_UNIT];
  phys_t               phys_v [NUM_UNIT];
  logic                exc_level;

  function automatic logic sel(input ofs_t a, input ofs_t ofs);
    sel = (a == ofs);
  endfunction

  function automatic logic [31:0] word24(input addr_t v);
    word24 = {8'h00, v};
  endfunction

  // Unit 0 watches loads, unit 1 watches fetches
  assign acc_v[0]  = i_ld_valid;
  assign acc_rd[0] = !i_ld_write;
  assign acc_a[0]  = i_ld_addr;
  assign acc_v[1]  = i_if_valid;
  assign acc_rd[1] = 1'b1;
  assign acc_a[1]  = i_if_addr;

  assign unit_en[0] = s_q.data_on;
  assign unit_en[1] = s_q.insn_on && SECOND_INSTANCE_OPTION;
  // Fixed mapping leaves data free to reach either half
  assign unit_split[0] = s_q.insn_on && !FIXED_MAPPING_OPTION;
  assign unit_split[1] = s_q.insn_on;

  miss_if mi [NUM_UNIT] ();

  for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
    assign mi[u].valid   = acc_v[u];
    assign mi[u].is_read = acc_rd[u];
    assign mi[u].addr    = acc_a[u];
    assign mi[u].en      = unit_en[u];
    assign mi[u].ack     = ack[u];
    assign mi[u].fixed   = FIXED_MAPPING_OPTION;
    assign mi[u].split   = unit_split[u];
    assign mi[u].upper   = (u == 1);
    // Each unit sees only its own mask, so data traps on code pages only if the data mask covers them
    assign mi[u].rmask   = s_q.rmask[u];
    assign mi[u].pmask   = s_q.pmask[u];
    assign mi[u].match   = s_q.match[u];
    assign mi[u].base    = s_q.base[u];
    assign miss_v[u]     = mi[u].miss;
    assign hit_v[u]      = mi[u].hit;
    assign flag_v[u]     = mi[u].flag;
    assign page_v[u]     = mi[u].page;
    assign phys_v[u]     = mi[u].phys;

    miss_detect u_det (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .bus      (mi[u])
    );
  end

  assign exc_level = |flag_v;

  exc_gate u_gate (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_exc     (exc_level),
    .i_irq     (i_irq_src),
    .o_int     (o_cpu_int),
    .o_exc_sel (o_exc_vector_zero)
  );

  // Kept out of the register process so the miss feedback forms no loop
  assign ack = {i_wdata[CMD_INSN_ACK], i_wdata[CMD_DATA_ACK]} & {NUM_UNIT{i_wr && sel(i_addr, OFS_CMD)}};

  always_comb begin
    s_d = s_q;
    if (i_wr) begin
      if (sel(i_addr, OFS_CMD)) begin
        s_d.data_on = i_wdata[CMD_DATA_ON];
        s_d.insn_on = i_wdata[CMD_INSN_ON] & SECOND_INSTANCE_OPTION;
      end else if (sel(i_addr, OFS_IMASK)) begin
        s_d.imask = i_wdata[NUM_UNIT-1:0];
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        if (sel(i_addr, OFS_BASE[u])) begin
          s_d.base[u] = i_wdata[PHYS_W-1:0];
        end
        if (sel(i_addr, OFS_RMASK[u])) begin
          s_d.rmask[u] = i_wdata[ADDR_W-1:0];
        end
        if (sel(i_addr, OFS_PMASK[u])) begin
          s_d.pmask[u] = i_wdata[ADDR_W-1:0];
        end
        if (sel(i_addr, OFS_MATCH[u])) begin
          s_d.match[u] = i_wdata[ADDR_W-1:0];
        end
      end
    end

    // Read data stand one cycle only, zero otherwise
    s_d.rdata = '0;
    if (i_rd) begin
      if (sel(i_addr, OFS_FLAGS)) begin
        s_d.rdata[FLG_DATA_MISS] = flag_v[0];
        s_d.rdata[FLG_INSN_MISS] = flag_v[1];
        s_d.rdata[FLG_DATA_ON]   = s_q.data_on;
        s_d.rdata[FLG_INSN_ON]   = s_q.insn_on;
      end else if (sel(i_addr, OFS_ISTAT)) begin
        s_d.rdata[NUM_UNIT-1:0] = s_q.istat;
      end else if (sel(i_addr, OFS_IMASK)) begin
        s_d.rdata[NUM_UNIT-1:0] = s_q.imask;
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        if (sel(i_addr, OFS_BASE[u])) begin
          s_d.rdata[PHYS_W-1:0] = s_q.base[u];
        end
        if (sel(i_addr, OFS_RMASK[u])) begin
          s_d.rdata = word24(s_q.rmask[u]);
        end
        if (sel(i_addr, OFS_PMASK[u])) begin
          s_d.rdata = word24(s_q.pmask[u]);
        end
        if (sel(i_addr, OFS_MATCH[u])) begin
          s_d.rdata = word24(s_q.match[u]);
        end
        if (sel(i_addr, OFS_PAGE[u])) begin
          s_d.rdata = word24(page_v[u]);
        end
      end
    end

    // Read clears; a miss in the same cycle still lands
    if (i_rd && sel(i_addr, OFS_ISTAT)) begin
      s_d.istat = '0;
    end
    s_d.istat = s_d.istat | miss_v;
    s_d.irq   = |(s_d.istat & s_d.imask);

    s_d.hit = hit_v;
    for (int u = 0; u < NUM_UNIT; u++) begin
      s_d.phys[u] = phys_v[u];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{data_on: 1'b0, insn_on: 1'b0,
               rmask: {NUM_UNIT{RST_ADDR}}, pmask: {NUM_UNIT{RST_ADDR}},
               match: {NUM_UNIT{RST_ADDR}}, base: {NUM_UNIT{RST_BASE}},
               istat: '0, imask: '0, rdata: '0, hit: '0,
               phys: {NUM_UNIT{RST_BASE}}, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata   = s_q.rdata;
  assign o_ld_hit  = s_q.hit[0];
  assign o_ld_phys = s_q.phys[0];
  assign o_if_hit  = s_q.hit[1];
  assign o_if_phys = s_q.phys[1];
  assign o_irq     = s_q.irq;

  a_write_no_trap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ld_valid && i_ld_write |-> !miss_v[0])
    else $error("store raised a data miss");

  a_region_trap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ld_valid && !i_ld_write && s_q.data_on && !flag_v[0]
    && ((i_ld_addr & s_q.rmask[0]) != s_q.match[0]) |-> !miss_v[0] && !hit_v[0])
    else $error("access outside region was caught");

  a_page_capture: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !FIXED_MAPPING_OPTION && miss_v[0] |=> flag_v[0]
    && page_v[0] == ($past(i_ld_addr) & $past(s_q.rmask[0]) & $past(s_q.pmask[0])))
    else $error("miss page not captured");

  a_data_off_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !s_q.data_on |-> !miss_v[0] ##1 !o_ld_hit)
    else $error("data unit active while off");

  a_ack_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_wr && sel(i_addr, OFS_CMD) && i_wdata[CMD_DATA_ACK] && !miss_v[0]
    |=> !flag_v[0])
    else $error("acknowledge left data flag set");

  a_exc_path: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    miss_v[0] |=> flag_v[0] ##1 (o_cpu_int && o_exc_vector_zero))
    else $error("miss did not reach exception vector");

  a_flag_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    flag_v[0] && !ack[0] |=> flag_v[0] && $stable(page_v[0]))
    else $error("pending miss page changed");

  a_flags_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd && sel(i_addr, OFS_FLAGS) |=> o_rdata[FLG_DATA_MISS] == $past(flag_v[0])
    && o_rdata[FLG_INSN_MISS] == $past(flag_v[1]))
    else $error("flags read wrong");

  a_code_half: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    hit_v[1] |=> o_if_hit && o_if_phys[PHYS_W-1])
    else $error("fetch hit outside upper half");

  a_data_half: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !FIXED_MAPPING_OPTION && hit_v[0] && s_q.insn_on |=> !o_ld_phys[PHYS_W-1])
    else $error("data hit outside lower half");

  a_irq_raise: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    miss_v[0] && s_q.imask[0] && !i_wr |=> o_irq)
    else $error("unmasked miss gave no interrupt");

  a_load_watched: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ld_valid && !i_ld_write && s_q.data_on && !flag_v[0]
    && ((i_ld_addr & s_q.rmask[0]) == s_q.match[0]) |-> miss_v[0] || hit_v[0])
    else $error("watched load neither hit nor missed");

  a_page_readback: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd && sel(i_addr, OFS_PAGE[0]) |=> o_rdata == word24($past(page_v[0])))
    else $error("data miss page read wrong");

  a_insn_page_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd && sel(i_addr, OFS_PAGE[1]) |=> o_rdata == word24($past(page_v[1])))
    else $error("fetch miss page read wrong");

  a_insn_capture: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !FIXED_MAPPING_OPTION && miss_v[1] |=> flag_v[1]
    && page_v[1] == ($past(i_if_addr) & $past(s_q.rmask[1]) & $past(s_q.pmask[1])))
    else $error("fetch miss page not captured");

  a_insn_off_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !s_q.insn_on |-> !miss_v[1] ##1 !o_if_hit)
    else $error("fetch unit active while off");

  a_data_base_add: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !FIXED_MAPPING_OPTION && !s_q.insn_on && hit_v[0] |=> o_ld_phys
    == $past(s_q.base[0] + phys_t'(i_ld_addr & ~(s_q.rmask[0] | s_q.pmask[0]))))
    else $error("data translation wrong");

  a_insn_base_add: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !FIXED_MAPPING_OPTION && hit_v[1] |=> (o_if_phys & 16'h7fff)
    == ($past(s_q.base[1] + phys_t'(i_if_addr & ~(s_q.rmask[1] | s_q.pmask[1]))) & 16'h7fff))
    else $error("fetch translation wrong");

  a_insn_trap_path: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    miss_v[1] |=> flag_v[1] ##1 (o_cpu_int && o_exc_vector_zero))
    else $error("fetch miss did not reach exception vector");

  a_data_mask_only: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    miss_v[0] |-> (i_ld_addr & s_q.rmask[0]) == s_q.match[0])
    else $error("data miss outside data region");

  a_flag_gives_exc: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (|flag_v) |=> o_exc_vector_zero && o_cpu_int)
    else $error("pending miss without exception");

  a_insn_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    flag_v[1] && !ack[1] |=> flag_v[1] && $stable(page_v[1]))
    else $error("pending fetch miss page changed");

  a_pending_stall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    flag_v[0] |-> !hit_v[0] && !miss_v[0])
    else $error("pending data miss still hit or missed");

  a_insn_ack_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ack[1] && !miss_v[1] |=> !flag_v[1])
    else $error("acknowledge left fetch flag set");

  a_stat_read_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd && sel(i_addr, OFS_ISTAT) && miss_v == '0 |=> s_q.istat == '0)
    else $error("status read did not clear");

  a_stat_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_q.istat[0] && !(i_rd && sel(i_addr, OFS_ISTAT)) |=> s_q.istat[0])
    else $error("status bit dropped unread");

  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data stood without read");
endmodule

// [tb/cpu_access_model.sv]
// CPU load, store and fetch path as seen by the miss trap.
// The bench calls access(); one access per call, all on i_clk.
`timescale 1ns/1ps
module cpu_access_model
  import soft_cache_ram_pkg::*;
(
  input  wire logic i_clk,
  output logic      o_ld_valid,
  output logic      o_ld_write,
  output addr_t     o_ld_addr,
  output logic      o_if_valid,
  output addr_t     o_if_addr
);
  initial begin
    o_ld_valid = 1'b0;
    o_ld_write = 1'b0;
    o_ld_addr  = 24'h00_0000;
    o_if_valid = 1'b0;
    o_if_addr  = 24'h00_0000;
  end

  // Kind 0 load, 1 store, 2 fetch
  task automatic access(input int kind, input addr_t a);
    @(posedge i_clk);
    o_ld_valid <= (kind < 2);
    o_ld_write <= (kind == 1);
    o_ld_addr  <= a;
    o_if_valid <= (kind == 2);
    o_if_addr  <= a;
    @(posedge i_clk);
    o_ld_valid <= 1'b0;
    o_if_valid <= 1'b0;
    // Idle lines flip so a stale value never matches by chance
    o_ld_write <= ~o_ld_write;
    o_ld_addr  <= ~a;
    o_if_addr  <= ~a;
  endtask
endmodule

// [tb/test_soft_cache_miss_trap.sv]
// Self-checking bench of the soft cache miss trap.
// Drives the register port and irq lines; the CPU model makes accesses.
`timescale 1ns/1ps
module test_soft_cache_miss_trap;
  import soft_cache_ram_pkg::*;
  logic               i_clk;
  logic               i_arst_n;
  logic               i_wr;
  logic               i_rd;
  logic [REG_AW-1:0]  i_addr;
  logic [31:0]        i_wdata;
  logic [31:0]        o_rdata;
  logic [31:0]        rv;
  logic [NUM_IRQ-1:0] i_irq_src;
  logic               ld_valid;
  logic               ld_write;
  logic               if_valid;
  addr_t              ld_addr;
  addr_t              if_addr;
  logic               o_ld_hit;
  logic               o_if_hit;
  logic               o_cpu_int;
  logic               o_exc_vector_zero;
  logic               o_irq;
  phys_t              o_ld_phys;
  phys_t              o_if_phys;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  int                 cycles = 0;

  localparam addr_t D_RM = 24'h03_8000;
  localparam addr_t D_PM = 24'h0f_f000;
  localparam addr_t D_MT = 24'h01_0000;
  localparam addr_t I_RM = 24'hf0_0000;
  localparam addr_t I_PM = 24'hff_f000;
  localparam addr_t I_MT = 24'h80_0000;
  localparam phys_t D_BASE = 16'h8100;
  localparam phys_t I_BASE = 16'h0040;
  localparam addr_t DA = 24'h01_1600;
  localparam addr_t IA = 24'h80_1234;
  localparam ofs_t  CFG_OFS [6] = '{6'h10, 6'h14, 6'h18, 6'h20, 6'h24, 6'h28};
  localparam addr_t CFG_VAL [6] = '{D_RM, D_PM, D_MT, I_RM, I_PM, I_MT};

  soft_cache_miss_trap soft_cache_miss_trap_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ld_valid(ld_valid),
    .i_ld_write(ld_write), .i_ld_addr(ld_addr), .i_if_valid(if_valid),
    .i_if_addr(if_addr), .i_irq_src(i_irq_src), .o_ld_hit(o_ld_hit),
    .o_ld_phys(o_ld_phys), .o_if_hit(o_if_hit), .o_if_phys(o_if_phys),
    .o_cpu_int(o_cpu_int), .o_exc_vector_zero(o_exc_vector_zero), .o_irq(o_irq)
  );

  cpu_access_model cpu_access_model_inst (
    .i_clk(i_clk), .o_ld_valid(ld_valid), .o_ld_write(ld_write),
    .o_ld_addr(ld_addr), .o_if_valid(if_valid), .o_if_addr(if_addr)
  );

  function automatic logic [31:0] page_of(addr_t a, addr_t rm, addr_t pm);
    return {8'h00, a & rm & pm};
  endfunction

  function automatic phys_t phys_of(addr_t a, addr_t rm, addr_t pm, phys_t b);
    addr_t off;
    off = a & ~(rm | pm);
    return b + off[15:0];
  endfunction

  task automatic wr(input ofs_t a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input ofs_t a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input ofs_t a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    i_arst_n  = 1'b0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    i_addr    = 6'h00;
    i_wdata   = 32'h0000_0000;
    i_irq_src = 4'h0;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rchk(OFS_FLAGS, 32'h0000_0000);
    rchk(6'h3c, 32'h0000_0000);
    @(posedge i_clk);
    i_irq_src <= 4'h1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_cpu_int, 1'b1);
    chk(o_exc_vector_zero, 1'b0);
    @(posedge i_clk);
    i_irq_src <= 4'h0;
    $display("test reset and irq done");

    for (int i = 0; i < 6; i++) wr(CFG_OFS[i], {8'h00, CFG_VAL[i]});
    for (int i = 0; i < 6; i++) rchk(CFG_OFS[i], {8'h00, CFG_VAL[i]});
    wr(OFS_BASE[0], {16'h0000, D_BASE});
    wr(OFS_BASE[1], {16'h0000, I_BASE});
    rchk(OFS_BASE[0], {16'h0000, D_BASE});
    wr(OFS_IMASK, 32'h0000_0003);
    rchk(OFS_IMASK, 32'h0000_0003);
    wr(OFS_CMD, 32'h0000_0001);
    rchk(OFS_FLAGS, 32'h0000_0004);
    $display("test config done");

    cpu_access_model_inst.access(1, DA);
    rchk(OFS_FLAGS, 32'h0000_0004);
    cpu_access_model_inst.access(0, DA);
    @(posedge i_clk);
    #1 chk(o_cpu_int, 1'b1);
    chk(o_exc_vector_zero, 1'b1);
    rchk(OFS_FLAGS, 32'h0000_0005);
    rchk(OFS_PAGE[0], page_of(DA, D_RM, D_PM));
    cpu_access_model_inst.access(0, 24'h01_2600);
    #1 chk(o_ld_hit, 1'b0);
    rchk(OFS_PAGE[0], page_of(DA, D_RM, D_PM));
    chk(o_irq, 1'b1);
    rchk(OFS_ISTAT, 32'h0000_0001);
    @(posedge i_clk);
    #1 chk(o_irq, 1'b0);
    chk(o_rdata, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0005);
    rchk(OFS_FLAGS, 32'h0000_0004);
    repeat (2) @(posedge i_clk);
    #1 chk(o_cpu_int, 1'b0);
    cpu_access_model_inst.access(0, DA + 24'h00_0004);
    #1 chk(o_ld_hit, 1'b1);
    chk(o_ld_phys, phys_of(DA + 24'h00_0004, D_RM, D_PM, D_BASE));
    cpu_access_model_inst.access(0, 24'h02_0000);
    #1 chk(o_ld_hit, 1'b0);
    rchk(OFS_FLAGS, 32'h0000_0004);
    $display("test data miss done");

    wr(OFS_CMD, 32'h0000_0003);
    cpu_access_model_inst.access(2, IA);
    @(posedge i_clk);
    #1 chk(o_cpu_int, 1'b1);
    rchk(OFS_FLAGS, 32'h0000_000e);
    rchk(OFS_PAGE[1], page_of(IA, I_RM, I_PM));
    rchk(OFS_ISTAT, 32'h0000_0002);
    wr(OFS_CMD, 32'h0000_000b);
    cpu_access_model_inst.access(2, IA + 24'h00_0004);
    #1 chk(o_if_hit, 1'b1);
    chk(o_if_phys, phys_of(IA + 24'h00_0004, I_RM, I_PM, I_BASE) | 16'h8000);
    cpu_access_model_inst.access(0, DA);
    #1 chk(o_ld_hit, 1'b1);
    chk(o_ld_phys, phys_of(DA, D_RM, D_PM, D_BASE) & 16'h7fff);
    $display("test fetch miss done");

    wr(OFS_CMD, 32'h0000_0002);
    cpu_access_model_inst.access(0, DA);
    #1 chk(o_ld_hit, 1'b0);
    rchk(OFS_FLAGS, 32'h0000_0008);
    $display("test data off done");
    give_verdict();
  end
endmodule
